// >>> common/usbg_defines.svh
// Register offsets, field positions, reset values and timing counts for the USART support block
`ifndef USBG_DEFINES_SVH
`define USBG_DEFINES_SVH

// Register byte offsets on APB
`define USBG_OFF_PRESCALE 12'h000
`define USBG_OFF_DIVLOW 12'h004
`define USBG_OFF_CTRL 12'h008
`define USBG_OFF_RXCTRL 12'h00c
`define USBG_OFF_IRQCTRL 12'h010
`define USBG_OFF_TXBUF 12'h014
`define USBG_OFF_RXBUF 12'h018
`define USBG_OFF_POWER 12'h01c

// Prescale select register fields
`define USBG_PSEL_MSB 7
`define USBG_PSEL_LSB 3
`define USBG_DIVHI_MSB 2

// Control register fields
`define USBG_CTRL_TX_NINTH_BIT 0
`define USBG_CTRL_CHAR_LEN_SEL_LO 1
`define USBG_CTRL_CHAR_LEN_SEL_HI 2
`define USBG_CTRL_PEN 3
`define USBG_CTRL_TX_BUFFER_EMPTY_FLAG 4

// Receive control register fields
`define USBG_RX_OVERRUN 0
`define USBG_RX_FRAMING 1
`define USBG_RX_PARITY 2
`define USBG_RX_RX_BUFFER_FULL_FLAG 3
`define USBG_RX_ADDRESS_WAIT_SELECT 4
`define USBG_RX_RX_NINTH_BIT 5
`define USBG_RX_BITOP 6

// Irq control register fields
`define USBG_IRQ_ERI 0
`define USBG_IRQ_ETI 1
`define USBG_IRQ_SYNC 2
`define USBG_IRQ_BRK 3

// Power register fields
`define USBG_PWR_HALT 0
`define USBG_PWR_IDLE 1
`define USBG_PWR_XTAL 2
`define USBG_PWR_HELD 3

// Reset values
`define USBG_PRESCALE_RST 8'h00
`define USBG_DIVLOW_RST 8'h00

// Oversampling ratios
`define USBG_OVS_ASYNC 5'h10
`define USBG_OVS_SYNC 5'h02

// Oscillator settle time in instruction cycles, 1 cycle = 1 pclk here
`define USBG_SETTLE_TC 256
`define USBG_SETTLE_CYC 9'h100
`endif

// >>> common/usbg_pkg.sv
// Types shared by the USART support block
package usbg_pkg;
    typedef enum logic [1:0] {
        USBG_RUN,
        USBG_SLEEP,
        USBG_SETTLE
    } usbg_pwr_t;

    typedef enum logic [1:0] {
        USBG_TX_IDLE,
        USBG_TX_SHIFT
    } usbg_tx_t;
endpackage

// >>> rtl/usbg_prescaler.sv
// Half-step prescaler: divides pclk by (code+1)/2
`timescale 1ns/1ns
`default_nettype none
module usbg_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] code,
    output logic tick
);
    // Accumulate 2 per clock, fire when reaching code+1 (factor = (code+1)/2)
    logic [5:0] acc_q;
    logic [5:0] lim;
    logic [5:0] sum;

    assign lim = {1'b0, code} + 6'h01;
    assign sum = acc_q + 6'h02;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= 6'h00;
            tick <= 1'b0;
        end
        else if (code == 5'h00)
        begin
            acc_q <= 6'h00;
            tick <= 1'b0;
        end
        else if (sum >= lim)
        begin
            acc_q <= sum - lim;
            tick <= 1'b1;
        end
        else
        begin
            acc_q <= sum;
            tick <= 1'b0;
        end
    end
endmodule // usbg_prescaler
`default_nettype wire

// >>> rtl/usbg_divisor.sv
// Eleven-bit divisor stage: one tick per stored value plus one input pulses
`timescale 1ns/1ns
`default_nettype none
module usbg_divisor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic in_tick,
    input wire logic [10:0] nm1,
    output logic out_tick
);
    logic [10:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 11'h000;
            out_tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= 11'h000;
            out_tick <= 1'b0;
        end
        else if (in_tick)
        begin
            if (cnt_q >= nm1)
            begin
                cnt_q <= 11'h000;
                out_tick <= 1'b1;
            end
            else
            begin
                cnt_q <= cnt_q + 11'h001;
                out_tick <= 1'b0;
            end
        end
        else
        begin
            out_tick <= 1'b0;
        end
    end
endmodule // usbg_divisor
`default_nettype wire

// >>> rtl/usbg_core.sv
// USART baud generator, low-power reinit, wake-up, loopback, attention and break
`include "usbg_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module usbg_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_data_pin,
    output logic tx_data_pin,
    output logic wakeup_req,
    output logic cpu_hold,
    output logic rx_irq,
    output logic tx_irq,
    output logic bit_tick
);
    logic [7:0] usart_prescale_select_q;
    logic [7:0] usart_divisor_low_q;
    logic tx_ninth_bit_q;
    logic char_len_sel_lo_q;
    logic char_len_sel_hi_q;
    logic parity_en_q;
    logic tx_buffer_empty_flag_q;
    logic address_wait_select_q;
    logic rx_buffer_full_flag_q;
    logic rx_ninth_bit_q;
    logic [2:0] rx_err_q;
    logic rx_irq_en_q;
    logic tx_irq_en_q;
    logic sync_mode_q;
    logic line_break_ctrl_q;
    logic xtal_q;
    logic [7:0] tx_holding_buffer_q;
    logic [7:0] rx_holding_buffer_q;
    logic [9:0] tx_shift_register_q;
    logic [8:0] rx_shift_register_q;
    usbg_pkg::usbg_pwr_t pwr_q;
    usbg_pkg::usbg_tx_t tx_st_q;
    logic [8:0] settle_q;
    logic [3:0] tx_bits_q;
    logic [4:0] tx_os_q;
    logic rx_busy_q;
    logic [3:0] rx_bits_q;
    logic [4:0] rx_os_q;
    logic rx_prev_q;

    logic wr;
    logic rd;
    logic pre_tick;
    logic os_tick;
    logic [10:0] div_nm1;
    logic [4:0] ovs;
    logic loopback;
    logic nine_bit;
    logic rx_line;
    logic tx_line;
    logic sleep_enter;
    logic rx_done;
    logic rx_accept;
    logic tx_load;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // divisor high bits live under the prescale select
    assign div_nm1 = {usart_prescale_select_q[`USBG_DIVHI_MSB:0], usart_divisor_low_q};
    assign ovs = sync_mode_q ? `USBG_OVS_SYNC : `USBG_OVS_ASYNC;
    assign loopback = char_len_sel_lo_q && char_len_sel_hi_q;
    assign nine_bit = char_len_sel_hi_q;
    assign tx_line = tx_shift_register_q[0];
    assign rx_line = loopback ? tx_line : rx_data_pin;
    assign tx_data_pin = line_break_ctrl_q ? 1'b0 : tx_line;
    assign sleep_enter = (pwr_q == usbg_pkg::USBG_RUN) && wr
        && (paddr == `USBG_OFF_POWER)
        && (pwdata[`USBG_PWR_HALT] || pwdata[`USBG_PWR_IDLE]);
    assign wakeup_req = (pwr_q == usbg_pkg::USBG_SLEEP) && rx_prev_q && !rx_line;
    assign cpu_hold = (pwr_q != usbg_pkg::USBG_RUN);
    assign rx_irq = rx_buffer_full_flag_q && rx_irq_en_q;
    assign tx_irq = tx_buffer_empty_flag_q && tx_irq_en_q;
    assign tx_load = (tx_st_q == usbg_pkg::USBG_TX_IDLE) && !tx_buffer_empty_flag_q && os_tick;
    // Stop bit judged mid-bit, so a low stop is seen before the line idles
    assign rx_done = rx_busy_q && os_tick && (rx_os_q == (ovs >> 1))
        && (rx_bits_q == (nine_bit ? 4'ha : 4'h9));
    // in attention mode only ninth-bit-one characters are kept
    assign rx_accept = rx_done && (!address_wait_select_q || rx_shift_register_q[8]);

    usbg_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .code(usart_prescale_select_q[`USBG_PSEL_MSB:`USBG_PSEL_LSB]),
        .tick(pre_tick)
    );

    usbg_divisor u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(usart_prescale_select_q[`USBG_PSEL_MSB:`USBG_PSEL_LSB] != 5'h00),
        .in_tick(pre_tick),
        .nm1(div_nm1),
        .out_tick(os_tick)
    );

    // Baud registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            usart_prescale_select_q <= `USBG_PRESCALE_RST;
            usart_divisor_low_q <= `USBG_DIVLOW_RST;
        end
        else if (wr && paddr == `USBG_OFF_PRESCALE)
        begin
            usart_prescale_select_q <= pwdata[7:0];
        end
        else if (wr && paddr == `USBG_OFF_DIVLOW)
        begin
            usart_divisor_low_q <= pwdata[7:0];
        end
    end

    // Read/write control bits; all but xtal_q, which halt/idle entry loads, are unaffected by halt/idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ninth_bit_q <= 1'b0;
            char_len_sel_lo_q <= 1'b0;
            char_len_sel_hi_q <= 1'b0;
            parity_en_q <= 1'b0;
            rx_irq_en_q <= 1'b0;
            tx_irq_en_q <= 1'b0;
            sync_mode_q <= 1'b0;
            line_break_ctrl_q <= 1'b0;
            xtal_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `USBG_OFF_CTRL)
            begin
                tx_ninth_bit_q <= pwdata[`USBG_CTRL_TX_NINTH_BIT];
                char_len_sel_lo_q <= pwdata[`USBG_CTRL_CHAR_LEN_SEL_LO];
                char_len_sel_hi_q <= pwdata[`USBG_CTRL_CHAR_LEN_SEL_HI];
                parity_en_q <= pwdata[`USBG_CTRL_PEN];
            end
            if (wr && paddr == `USBG_OFF_IRQCTRL)
            begin
                rx_irq_en_q <= pwdata[`USBG_IRQ_ERI];
                tx_irq_en_q <= pwdata[`USBG_IRQ_ETI];
                sync_mode_q <= pwdata[`USBG_IRQ_SYNC];
                line_break_ctrl_q <= pwdata[`USBG_IRQ_BRK];
            end
            if (sleep_enter)
            begin
                xtal_q <= pwdata[`USBG_PWR_XTAL] && pwdata[`USBG_PWR_HALT];
            end
        end
    end

    // Attention select: software writes it, hardware clears it on an address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            address_wait_select_q <= 1'b0;
        end
        else if (rx_accept && address_wait_select_q)
        begin
            address_wait_select_q <= 1'b0;
        end
        else if (wr && paddr == `USBG_OFF_RXCTRL)
        begin
            address_wait_select_q <= pwdata[`USBG_RX_ADDRESS_WAIT_SELECT];
        end
    end

    // Power state and oscillator settle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_q <= usbg_pkg::USBG_RUN;
            settle_q <= 9'h000;
        end
        else
        begin
            unique case (pwr_q)
                usbg_pkg::USBG_RUN:
                begin
                    if (sleep_enter)
                    begin
                        pwr_q <= usbg_pkg::USBG_SLEEP;
                    end
                end
                usbg_pkg::USBG_SLEEP:
                begin
                    if (wakeup_req && xtal_q)
                    begin
                        pwr_q <= usbg_pkg::USBG_SETTLE;
                        settle_q <= `USBG_SETTLE_CYC - 9'h001;
                    end
                    else if (wakeup_req)
                    begin
                        pwr_q <= usbg_pkg::USBG_RUN;
                    end
                end
                usbg_pkg::USBG_SETTLE:
                begin
                    if (settle_q == 9'h000)
                    begin
                        pwr_q <= usbg_pkg::USBG_RUN;
                    end
                    else
                    begin
                        settle_q <= settle_q - 9'h001;
                    end
                end
                default:
                begin
                    pwr_q <= usbg_pkg::USBG_RUN;
                end
            endcase
        end
    end

    // Transmit path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_holding_buffer_q <= 8'h00;
            tx_buffer_empty_flag_q <= 1'b1;
            tx_shift_register_q <= 10'h3ff;
            tx_st_q <= usbg_pkg::USBG_TX_IDLE;
            tx_bits_q <= 4'h0;
            tx_os_q <= 5'h00;
        end
        else if (sleep_enter)
        begin
            tx_buffer_empty_flag_q <= 1'b1;
            tx_shift_register_q <= 10'h3ff;
            tx_st_q <= usbg_pkg::USBG_TX_IDLE;
            tx_bits_q <= 4'h0;
            tx_os_q <= 5'h00;
        end
        else
        begin
            if (wr && paddr == `USBG_OFF_TXBUF)
            begin
                tx_holding_buffer_q <= pwdata[7:0];
                tx_buffer_empty_flag_q <= 1'b0;
            end
            else if (tx_load)
            begin
                tx_buffer_empty_flag_q <= 1'b1;
            end
            if (tx_load)
            begin
                // Start bit, eight data, ninth bit or stop; parity not built in any mode
                tx_shift_register_q <= {nine_bit ? tx_ninth_bit_q : 1'b1,
                    tx_holding_buffer_q, 1'b0};
                tx_st_q <= usbg_pkg::USBG_TX_SHIFT;
                tx_bits_q <= 4'h0;
                tx_os_q <= 5'h00;
            end
            else if (tx_st_q == usbg_pkg::USBG_TX_SHIFT && os_tick)
            begin
                if (tx_os_q == ovs - 5'h01)
                begin
                    tx_os_q <= 5'h00;
                    tx_shift_register_q <= {1'b1, tx_shift_register_q[9:1]};
                    tx_bits_q <= tx_bits_q + 4'h1;
                    if (tx_bits_q == (nine_bit ? 4'ha : 4'h9))
                    begin
                        tx_st_q <= usbg_pkg::USBG_TX_IDLE;
                    end
                end
                else
                begin
                    tx_os_q <= tx_os_q + 5'h01;
                end
            end
        end
    end

    // Receive path; holding and shift registers survive halt/idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_holding_buffer_q <= 8'h00;
            rx_shift_register_q <= 9'h000;
            rx_buffer_full_flag_q <= 1'b0;
            rx_ninth_bit_q <= 1'b0;
            rx_err_q <= 3'h0;
            rx_busy_q <= 1'b0;
            rx_bits_q <= 4'h0;
            rx_os_q <= 5'h00;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            // Line history at oversampling rate, so a slow tick still sees the edge
            if (os_tick)
            begin
                rx_prev_q <= rx_line;
            end
            if (sleep_enter)
            begin
                rx_buffer_full_flag_q <= 1'b0;
                rx_ninth_bit_q <= 1'b0;
                rx_err_q <= 3'h0;
                rx_busy_q <= 1'b0;
            end
            else
            begin
                if (rx_accept)
                begin
                    rx_holding_buffer_q <= rx_shift_register_q[7:0];
                    rx_ninth_bit_q <= rx_shift_register_q[8];
                    rx_buffer_full_flag_q <= 1'b1;
                    rx_err_q[`USBG_RX_OVERRUN] <= rx_buffer_full_flag_q;
                end
                else if (rd && paddr == `USBG_OFF_RXBUF)
                begin
                    rx_buffer_full_flag_q <= 1'b0;
                end
                if (rx_done)
                begin
                    rx_err_q[`USBG_RX_FRAMING] <= !rx_line;
                end
                else if (wr && paddr == `USBG_OFF_RXCTRL && pwdata[`USBG_RX_BITOP])
                begin
                    rx_err_q <= 3'h0;
                end
                if (!rx_busy_q && rx_prev_q && !rx_line && os_tick)
                begin
                    rx_busy_q <= 1'b1;
                    rx_bits_q <= 4'h0;
                    rx_os_q <= 5'h00;
                end
                else if (rx_busy_q && os_tick)
                begin
                    if (rx_done)
                    begin
                        rx_busy_q <= 1'b0;
                    end
                    if (rx_os_q == ovs - 5'h01)
                    begin
                        rx_os_q <= 5'h00;
                        rx_bits_q <= rx_bits_q + 4'h1;
                    end
                    else
                    begin
                        rx_os_q <= rx_os_q + 5'h01;
                    end
                    // Sample mid-bit data bits
                    if (rx_os_q == (ovs >> 1) && rx_bits_q != 4'h0
                        && rx_bits_q <= (nine_bit ? 4'h9 : 4'h8))
                    begin
                        rx_shift_register_q <= nine_bit ? {rx_line, rx_shift_register_q[8:1]}
                            : {1'b0, rx_line, rx_shift_register_q[7:1]};
                    end
                end
            end
        end
    end

    // Outputs and readback
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_tick <= 1'b0;
        end
        else
        begin
            bit_tick <= os_tick;
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `USBG_OFF_PRESCALE: prdata[7:0] = usart_prescale_select_q;
            `USBG_OFF_DIVLOW: prdata[7:0] = usart_divisor_low_q;
            `USBG_OFF_CTRL: prdata[4:0] = {tx_buffer_empty_flag_q, parity_en_q,
                char_len_sel_hi_q, char_len_sel_lo_q, tx_ninth_bit_q};
            `USBG_OFF_RXCTRL: prdata[5:0] = {rx_ninth_bit_q, address_wait_select_q,
                rx_buffer_full_flag_q, rx_err_q};
            `USBG_OFF_IRQCTRL: prdata[3:0] = {line_break_ctrl_q, sync_mode_q,
                tx_irq_en_q, rx_irq_en_q};
            `USBG_OFF_TXBUF: prdata[7:0] = tx_holding_buffer_q;
            `USBG_OFF_RXBUF: prdata[7:0] = rx_holding_buffer_q;
            `USBG_OFF_POWER: prdata[3:0] = {cpu_hold, xtal_q, 2'b00};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule // usbg_core
`default_nettype wire

// >>> tb/usbg_props.sv
// Port-level assertions for the USART support block
`include "usbg_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module usbg_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_data_pin,
    input wire logic tx_data_pin,
    input wire logic wakeup_req,
    input wire logic cpu_hold,
    input wire logic rx_irq,
    input wire logic tx_irq,
    input wire logic bit_tick
);
    logic wr;
    logic brk_q, eti_q, eri_q, xtal_q, stop_q;
    logic [1:0] zc_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr = psel && penable && pwrite && pready;
    // Shadows of the control bits seen on the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {brk_q, eti_q, eri_q} <= 3'h0;
        else if (wr && paddr == `USBG_OFF_IRQCTRL)
            {brk_q, eti_q, eri_q} <= {pwdata[3], pwdata[1], pwdata[0]};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xtal_q <= 1'b0;
        else if (wr && paddr == `USBG_OFF_POWER && pwdata[1:0] != 2'h0)
            xtal_q <= pwdata[0] && pwdata[2];
    end
    // Cycles since the prescale code went to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_q <= 1'b1;
        else if (wr && paddr == `USBG_OFF_PRESCALE)
            stop_q <= pwdata[7:3] == 5'h00;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            zc_q <= 2'h0;
        else if (!stop_q)
            zc_q <= 2'h0;
        else if (zc_q != 2'h3)
            zc_q <= zc_q + 2'h1;
    end
    sequence s_sleep;
        wr && paddr == `USBG_OFF_POWER && pwdata[1:0] != 2'h0;
    endsequence
    sequence s_xwake;
        wakeup_req && xtal_q;
    endsequence
    AST_STOPPED: assert property (zc_q == 2'h3 |-> !bit_tick)
        else $error("tick while prescaler stopped");
    AST_BREAK: assert property (brk_q |-> !tx_data_pin)
        else $error("line not low during break");
    AST_RXIRQ: assert property (rx_irq |-> eri_q)
        else $error("receive irq while disabled");
    AST_SLEEP_HOLD: assert property (s_sleep |-> ##[1:2] cpu_hold)
        else $error("sleep entry did not hold cpu");
    AST_SLEEP_TX: assert property (s_sleep ##0 eti_q |-> ##[1:2] tx_irq)
        else $error("sleep entry left tx not empty");
    AST_WAKE_HOLD: assert property (wakeup_req |-> cpu_hold)
        else $error("wake request while awake");
    AST_SETTLE: assert property (s_xwake |-> ##250 cpu_hold ##[1:10] !cpu_hold)
        else $error("settle delay wrong");
    AST_IDLE_WAKE: assert property (wakeup_req && !xtal_q |-> ##[1:4] !cpu_hold)
        else $error("no resume after wake");
endmodule // usbg_props
bind usbg_core usbg_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_data_pin(rx_data_pin),
    .tx_data_pin(tx_data_pin), .wakeup_req(wakeup_req), .cpu_hold(cpu_hold),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .bit_tick(bit_tick));
`default_nettype wire

// >>> tb/usbg_remote.sv
// Remote serial device driving the receive line
`timescale 1ns/1ns
`default_nettype none
module usbg_remote (
    input wire logic pclk,
    output logic line
);
    initial line = 1'b1;
    // Start, nine data bits LSB first, one stop bit, then idle high
    task automatic send(input logic [8:0] d, input logic stop, input int cyc);
        logic [10:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line <= f[i];
            repeat (cyc) @(posedge pclk);
        end
        line <= 1'b1;
    endtask
endmodule // usbg_remote
`default_nettype wire

// >>> tb/tb_usart_baud_and_aux_modes.sv
// Testbench for the USART support block
`include "usbg_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %0h not %0h", $time, a, b); end end
module tb_usart_baud_and_aux_modes;
    logic pclk, presetn, psel, penable, pwrite, rx_data_pin, tx_data_pin;
    logic pready, pslverr, wakeup_req, cpu_hold, rx_irq, tx_irq, bit_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_mismatch = 0;
    int n_compared = 0;
    usbg_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_data_pin(rx_data_pin),
        .tx_data_pin(tx_data_pin), .wakeup_req(wakeup_req), .cpu_hold(cpu_hold),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .bit_tick(bit_tick));
    usbg_remote REM (.pclk(pclk), .line(rx_data_pin));
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A wait that used up its bound
    task automatic give_up;
        n_mismatch++;
        end_sim;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int k;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            r = prdata[7:0];
            rdy = pready;
            k++;
        end while (rdy !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (rdy !== 1'b1)
            give_up;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] r);
        apb(1'b0, a, 8'h00, r);
    endtask
    // Oversampling tick spacing, measured over four periods
    task automatic tick_gap(input logic [4:0] c, input logic [10:0] n, input int p);
        int t, f, s;
        wr(`USBG_OFF_PRESCALE, 8'h00);
        wr(`USBG_OFF_DIVLOW, n[7:0]);
        wr(`USBG_OFF_PRESCALE, {c, n[10:8]});
        t = 0;
        f = 0;
        s = 0;
        while (s < 5 && t < 4000)
        begin
            @(negedge pclk);
            t++;
            if (bit_tick === 1'b1)
            begin
                s++;
                if (s == 1)
                    f = t;
            end
        end
        if (s < 5)
            give_up;
        `CHK(t - f, 4 * p)
    endtask
    // Width of the start bit of a frame of all ones
    task automatic start_len(input int p);
        int t, w;
        wr(`USBG_OFF_TXBUF, 8'hff);
        t = 0;
        w = 0;
        while (t < 500 && (w == 0 || tx_data_pin === 1'b0))
        begin
            @(negedge pclk);
            t++;
            if (tx_data_pin === 1'b0)
                w++;
        end
        if (t >= 500)
            give_up;
        `CHK(w, p)
    endtask
    task automatic wait_full(output logic [7:0] v);
        int k;
        v = 8'h00;
        for (k = 0; k < 200 && v[3] !== 1'b1; k++)
            rd(`USBG_OFF_RXCTRL, v);
        if (v[3] !== 1'b1)
            give_up;
    endtask
    task automatic hold_len(output int n);
        n = 0;
        while (n < 1000 && cpu_hold !== 1'b0)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= 1000)
            give_up;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        logic [7:0] v;
        int n;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`USBG_OFF_PRESCALE, v);
        `CHK(v, 8'h00)
        `CHK({tx_data_pin, tx_irq, rx_irq}, 3'b100)
        tick_gap(5'h01, 11'h002, 3);
        tick_gap(5'h02, 11'h001, 3);
        tick_gap(5'h1f, 11'h000, 16);
        tick_gap(5'h03, 11'h100, 514);
        tick_gap(5'h01, 11'h000, 1);
        start_len(16);
        repeat (300) @(posedge pclk);
        wr(`USBG_OFF_IRQCTRL, 8'h04);
        start_len(2);
        repeat (50) @(posedge pclk);
        wr(`USBG_OFF_IRQCTRL, 8'h00);
        wr(`USBG_OFF_CTRL, 8'h07);
        wr(`USBG_OFF_TXBUF, 8'ha5);
        wait_full(v);
        `CHK(v[5], 1'b1)
        rd(`USBG_OFF_RXBUF, v);
        `CHK(v, 8'ha5)
        wr(`USBG_OFF_CTRL, 8'h04);
        wr(`USBG_OFF_RXCTRL, 8'h10);
        wr(`USBG_OFF_IRQCTRL, 8'h01);
        REM.send(9'h033, 1'b1, 16);
        repeat (20) @(posedge pclk);
        rd(`USBG_OFF_RXCTRL, v);
        `CHK({v[4], v[3], rx_irq}, 3'b100)
        REM.send(9'h15a, 1'b1, 16);
        wait_full(v);
        `CHK({v[5:3], rx_irq}, 4'b1011)
        rd(`USBG_OFF_RXBUF, v);
        `CHK(v, 8'h5a)
        REM.send(9'h0f0, 1'b0, 16);
        repeat (40) @(posedge pclk);
        rd(`USBG_OFF_RXCTRL, v);
        `CHK(v[1], 1'b1)
        wr(`USBG_OFF_RXCTRL, 8'h40);
        rd(`USBG_OFF_RXCTRL, v);
        `CHK(v[2:0], 3'h0)
        wr(`USBG_OFF_IRQCTRL, 8'h08);
        repeat (30) @(posedge pclk);
        `CHK(tx_data_pin, 1'b0)
        wr(`USBG_OFF_IRQCTRL, 8'h02);
        repeat (2) @(posedge pclk);
        `CHK(tx_data_pin, 1'b1)
        wr(`USBG_OFF_TXBUF, 8'h11);
        wr(`USBG_OFF_POWER, 8'h05);
        rd(`USBG_OFF_RXCTRL, v);
        `CHK({v[3], cpu_hold, tx_irq, tx_data_pin}, 4'b0111)
        rd(`USBG_OFF_RXBUF, v);
        `CHK(v, 8'hf0)
        fork
            REM.send(9'h1ff, 1'b1, 16);
            hold_len(n);
        join
        `CHK(n >= 256 && n <= 262, 1'b1)
        wr(`USBG_OFF_POWER, 8'h02);
        @(posedge pclk);
        `CHK(cpu_hold, 1'b1)
        fork
            REM.send(9'h1ff, 1'b1, 16);
            hold_len(n);
        join
        `CHK(n <= 6, 1'b1)
        end_sim;
    end
endmodule // tb_usart_baud_and_aux_modes
`default_nettype wire
